// [ddrb2_ctl.sv]
// Controller end: request FIFO, power-up sequencing, command and data timing
`timescale 1ns/1ps
`default_nettype none
`include "ddrb2_defines.svh"
module ddrb2_fifo #(
    parameter int W = 8,
    parameter int DEPTH = `DDRB2_FIFO_DEPTH
) (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [W-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [W-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wp_ff;
    logic [AW-1:0] rp_ff;
    logic [AW:0] cnt_ff;
    logic rdy_ff;
    wire push;
    wire pop;
    wire [AW:0] nxt_cnt;

    assign push = in_valid_in && rdy_ff;
    assign pop = out_valid_out && out_ready_in;
    assign nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    assign out_valid_out = cnt_ff != '0;
    assign out_data_out = mem_ff[rp_ff];
    assign in_ready_out = rdy_ff;

    always_ff @(posedge CLK_IN)
    begin
        if (push)
        begin
            mem_ff[wp_ff] <= in_data_in;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
            cnt_ff <= '0;
            rdy_ff <= 1'b0;
        end
        else
        begin
            wp_ff <= push ? AW'(wp_ff + 1'b1) : wp_ff;
            rp_ff <= pop ? AW'(rp_ff + 1'b1) : rp_ff;
            cnt_ff <= nxt_cnt;
            rdy_ff <= nxt_cnt < (AW+1)'(DEPTH);
        end
    end
endmodule

module ddrb2_ctl #(
    parameter int IMP_CYCLES = `DDRB2_IMP_CYC,
    parameter int LOCK_CYCLES = `DDRB2_LOCK_CYC
) (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    ddrb2_if.ctl BUS,
    input wire logic REQ_VALID_IN,
    output logic REQ_READY_OUT,
    input wire logic REQ_RD_IN,
    input wire logic [`DDRB2_ADDR_W-1:0] REQ_ADDR_IN,
    input wire logic [2*`DDRB2_DQ_W-1:0] REQ_WDATA_IN,
    input wire logic [2*`DDRB2_LANES-1:0] REQ_MASK_N_IN,
    input wire logic RELOCK_IN,
    output logic READY_OUT,
    output logic RD_VALID_OUT,
    output logic [2*`DDRB2_DQ_W-1:0] RD_DATA_OUT
);
    localparam int RW = $bits(ddrb2_pkg::ddrb2_req_s);
    localparam int DW = `DDRB2_DQ_W;
    localparam int MW = `DDRB2_LANES;

    ddrb2_pkg::ddrb2_ctl_e state_ff;
    ddrb2_pkg::ddrb2_ctl_e nxt_state;
    ddrb2_pkg::ddrb2_cmd_e cp_ff [`DDRB2_PIPE];
    logic [`DDRB2_CNT_W-1:0] cnt_ff;
    logic [`DDRB2_CNT_W-1:0] nxt_cnt;
    logic k_ff;
    logic doff_n_ff;
    logic ready_ff;
    logic ld_n_ff;
    logic rw_ff;
    logic [`DDRB2_ADDR_W-1:0] addr_ff;
    logic [1:0] gap_ff;
    ddrb2_pkg::ddrb2_req_s hold_ff;
    logic [DW-1:0] b2_ff;
    logic [MW-1:0] b2m_ff;
    logic [DW-1:0] dq_ff;
    logic [MW-1:0] mask_ff;
    logic oe_n_ff;
    logic [DW-1:0] rlo_ff;
    logic rv_ff;
    logic [2*DW-1:0] rdat_ff;

    wire [RW-1:0] f_data;
    wire f_valid;
    wire k_next;
    wire pop;
    wire wb1;
    wire wb2;
    ddrb2_pkg::ddrb2_req_s req;

    ddrb2_fifo #(.W(RW), .DEPTH(`DDRB2_FIFO_DEPTH)) ddrb2_fifo_i (
        .CLK_IN(CLK_IN),
        .RESETN_IN(RESETN_IN),
        .in_valid_in(REQ_VALID_IN),
        .in_ready_out(REQ_READY_OUT),
        .in_data_in({REQ_RD_IN, REQ_ADDR_IN, REQ_WDATA_IN, REQ_MASK_N_IN}),
        .out_valid_out(f_valid),
        .out_ready_in(pop),
        .out_data_out(f_data)
    );

    assign req = f_data;
    assign k_next = !k_ff;
    // A write waits two primary slots after a read so the bus turns round
    assign pop = state_ff == ddrb2_pkg::ST_RUN && k_next && f_valid &&
                 (req.rd || gap_ff == 2'h0);
    assign wb1 = cp_ff[`DDRB2_ST_WB1] == ddrb2_pkg::CMD_WR;
    assign wb2 = cp_ff[`DDRB2_ST_WB2] == ddrb2_pkg::CMD_WR;

    // Power-up: impedance wait with DLL off, then lock wait with it on
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        unique case (state_ff)
            ddrb2_pkg::ST_IMP:
            begin
                if (k_next)
                begin
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff == `DDRB2_CNT_W'(IMP_CYCLES - 1))
                    begin
                        nxt_state = ddrb2_pkg::ST_LOCK;
                        nxt_cnt = '0;
                    end
                end
            end
            ddrb2_pkg::ST_LOCK:
            begin
                if (k_next)
                begin
                    nxt_cnt = cnt_ff + 1'b1;
                    if (cnt_ff == `DDRB2_CNT_W'(LOCK_CYCLES - 1))
                    begin
                        nxt_state = ddrb2_pkg::ST_RUN;
                        nxt_cnt = '0;
                    end
                end
            end
            ddrb2_pkg::ST_RUN:
            begin
                if (RELOCK_IN)
                begin
                    nxt_state = ddrb2_pkg::ST_RELOCK;
                end
            end
            ddrb2_pkg::ST_RELOCK:
            begin
                if (k_next)
                begin
                    nxt_state = ddrb2_pkg::ST_LOCK;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            state_ff <= ddrb2_pkg::ST_IMP;
            cnt_ff <= '0;
            k_ff <= 1'b0;
            doff_n_ff <= 1'b0;
            ready_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            k_ff <= !k_ff;
            doff_n_ff <= nxt_state == ddrb2_pkg::ST_LOCK ||
                         nxt_state == ddrb2_pkg::ST_RUN;
            ready_ff <= nxt_state == ddrb2_pkg::ST_RUN;
        end
    end

    // Command pins change only ahead of a primary edge, except the load strobe, which rises again one cycle later
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            ld_n_ff <= 1'b1;
            rw_ff <= 1'b1;
            addr_ff <= '0;
            gap_ff <= '0;
            hold_ff <= '0;
            for (int i = 0; i < `DDRB2_PIPE; i++)
            begin
                cp_ff[i] <= ddrb2_pkg::CMD_NOP;
            end
        end
        else
        begin
            ld_n_ff <= !pop;
            if (pop)
            begin
                rw_ff <= req.rd;
                addr_ff <= req.addr;
                hold_ff <= req;
            end
            if (k_next)
            begin
                gap_ff <= (pop && req.rd) ? `DDRB2_RD_GAP :
                          (gap_ff != 2'h0 ? gap_ff - 2'h1 : 2'h0);
            end
            cp_ff[0] <= !pop ? ddrb2_pkg::CMD_NOP :
                        (req.rd ? ddrb2_pkg::CMD_RD : ddrb2_pkg::CMD_WR);
            for (int i = 1; i < `DDRB2_PIPE; i++)
            begin
                cp_ff[i] <= cp_ff[i - 1];
            end
        end
    end

    // Write beats on the next primary and then the inverted edge
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            dq_ff <= '0;
            mask_ff <= '1;
            oe_n_ff <= 1'b1;
            b2_ff <= '0;
            b2m_ff <= '1;
        end
        else
        begin
            oe_n_ff <= !(wb1 || wb2);
            if (wb1)
            begin
                dq_ff <= hold_ff.data[DW-1:0];
                mask_ff <= hold_ff.mask_n[MW-1:0];
                b2_ff <= hold_ff.data[2*DW-1:DW];
                b2m_ff <= hold_ff.mask_n[2*MW-1:MW];
            end
            else if (wb2)
            begin
                dq_ff <= b2_ff;
                mask_ff <= b2m_ff;
            end
            else
            begin
                dq_ff <= '0;
                mask_ff <= '1;
            end
        end
    end

    // Read beats return in the third primary cycle after the command
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            rlo_ff <= '0;
            rv_ff <= 1'b0;
            rdat_ff <= '0;
        end
        else
        begin
            if (cp_ff[`DDRB2_ST_CAP1] == ddrb2_pkg::CMD_RD)
            begin
                rlo_ff <= BUS.dq;
            end
            rv_ff <= cp_ff[`DDRB2_ST_CAP2] == ddrb2_pkg::CMD_RD;
            if (cp_ff[`DDRB2_ST_CAP2] == ddrb2_pkg::CMD_RD)
            begin
                rdat_ff <= {BUS.dq, rlo_ff};
            end
        end
    end

    assign BUS.k_phase = k_ff;
    assign BUS.doff_n = doff_n_ff;
    assign BUS.load_strobe_n = ld_n_ff;
    assign BUS.rd_wr_n = rw_ff;
    assign BUS.word_address_inputs = addr_ff;
    assign BUS.lane_write_mask_n = mask_ff;
    assign BUS.dq_ctl_out = dq_ff;
    assign BUS.dq_ctl_oe_n = oe_n_ff;
    assign READY_OUT = ready_ff;
    assign RD_VALID_OUT = rv_ff;
    assign RD_DATA_OUT = rdat_ff;
endmodule
`default_nettype wire

// [ddrb2_defines.svh]
// Shared constants of the burst-of-two double-rate SRAM core and its controller
`ifndef DDRB2_DEFINES_SVH
`define DDRB2_DEFINES_SVH

`define DDRB2_DQ_W 36
`define DDRB2_LANES 4
`define DDRB2_LANE_W 9
`define DDRB2_WORD_W 18
`define DDRB2_CHK_W 5
`define DDRB2_CW_W 23
`define DDRB2_ADDR_W 4
`define DDRB2_DEPTH 16
`define DDRB2_PIPE 7
`define DDRB2_ST_WB1 1
`define DDRB2_ST_WB2 2
`define DDRB2_ST_RD1 3
`define DDRB2_ST_RD2 4
`define DDRB2_ST_CAP1 5
`define DDRB2_ST_CAP2 6
`define DDRB2_CLK_NS 50
`define DDRB2_STOP_NS 30
`define DDRB2_STOP_CYC ((`DDRB2_STOP_NS + `DDRB2_CLK_NS - 1) / `DDRB2_CLK_NS)
`define DDRB2_IMP_CYC 163840
`define DDRB2_LOCK_CYC 65536
`define DDRB2_CNT_W 18
`define DDRB2_LOCK_W 17
`define DDRB2_RD_GAP 2'h2
`define DDRB2_FIFO_DEPTH 8

`endif

// [ddrb2_pkg.sv]
// Types of both ends and the error-correction functions of the memory end
`include "ddrb2_defines.svh"
package ddrb2_pkg;

    typedef enum logic [1:0] {CMD_NOP, CMD_WR, CMD_RD} ddrb2_cmd_e;

    typedef enum logic [1:0] {ST_IMP, ST_LOCK, ST_RUN, ST_RELOCK} ddrb2_ctl_e;

    typedef struct packed {
        logic rd;
        logic [`DDRB2_ADDR_W-1:0] addr;
        logic [2*`DDRB2_DQ_W-1:0] data;
        logic [2*`DDRB2_LANES-1:0] mask_n;
    } ddrb2_req_s;

    // Hamming code: check bits at power-of-two positions 1,2,4,8,16
    function automatic logic [`DDRB2_CW_W-1:0] ham_enc(
        input logic [`DDRB2_WORD_W-1:0] d);
        logic [`DDRB2_CW_W-1:0] cw;
        int k;
        cw = '0;
        k = 0;
        for (int p = 1; p <= `DDRB2_CW_W; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                cw[p - 1] = d[k];
                k++;
            end
        end
        for (int b = 0; b < `DDRB2_CHK_W; b++)
        begin
            for (int p = 1; p <= `DDRB2_CW_W; p++)
            begin
                if (((p >> b) & 1) == 1 && p != (1 << b))
                begin
                    cw[(1 << b) - 1] = cw[(1 << b) - 1] ^ cw[p - 1];
                end
            end
        end
        return cw;
    endfunction

    function automatic logic [`DDRB2_CHK_W-1:0] ham_syn(
        input logic [`DDRB2_CW_W-1:0] cw);
        logic [`DDRB2_CHK_W-1:0] s;
        s = '0;
        for (int p = 1; p <= `DDRB2_CW_W; p++)
        begin
            if (cw[p - 1])
            begin
                s = s ^ p[`DDRB2_CHK_W-1:0];
            end
        end
        return s;
    endfunction

    // Flips the bit the syndrome points at when fix is set; a multi-bit
    // error is not repaired: a syndrome of 1 to 23 flips the bit it names, a larger one flips none.
    function automatic logic [`DDRB2_WORD_W-1:0] ham_dec(
        input logic [`DDRB2_CW_W-1:0] cw,
        input logic fix);
        logic [`DDRB2_CW_W-1:0] c;
        logic [`DDRB2_CHK_W-1:0] s;
        logic [`DDRB2_WORD_W-1:0] d;
        int k;
        c = cw;
        s = ham_syn(cw);
        d = '0;
        k = 0;
        if (fix && s != '0 && s <= `DDRB2_CHK_W'(`DDRB2_CW_W))
        begin
            c[s - 1'b1] = ~c[s - 1'b1];
        end
        for (int p = 1; p <= `DDRB2_CW_W; p++)
        begin
            if ((p & (p - 1)) != 0)
            begin
                d[k] = c[p - 1];
                k++;
            end
        end
        return d;
    endfunction

endpackage

// [ddrb2_if.sv]
// Pin bundle between the SRAM core and its memory controller
`timescale 1ns/1ps
`default_nettype none
`include "ddrb2_defines.svh"
interface ddrb2_if;
    logic k_phase;
    logic doff_n;
    logic load_strobe_n;
    logic rd_wr_n;
    logic [`DDRB2_ADDR_W-1:0] word_address_inputs;
    logic [`DDRB2_LANES-1:0] lane_write_mask_n;
    logic [`DDRB2_DQ_W-1:0] dq_ctl_out;
    logic dq_ctl_oe_n;
    logic [`DDRB2_DQ_W-1:0] dq_dev_out;
    logic dq_dev_oe_n;
    logic [`DDRB2_DQ_W-1:0] dq;

    // Resolved data bus; an idle bus reads as zero
    assign dq = !dq_dev_oe_n ? dq_dev_out :
                (!dq_ctl_oe_n ? dq_ctl_out : '0);

    modport ctl (
        output k_phase, doff_n, load_strobe_n, rd_wr_n,
        output word_address_inputs, lane_write_mask_n,
        output dq_ctl_out, dq_ctl_oe_n,
        input dq
    );

    modport dev (
        input k_phase, doff_n, load_strobe_n, rd_wr_n,
        input word_address_inputs, lane_write_mask_n,
        output dq_dev_out, dq_dev_oe_n,
        input dq
    );
endinterface
`default_nettype wire

// [ddrb2_dev.sv]
// Memory end: command pipeline, masked ECC array, read drivers, DLL lock
`timescale 1ns/1ps
`default_nettype none
`include "ddrb2_defines.svh"
module ddrb2_dev #(
    parameter int LOCK_CYCLES = `DDRB2_LOCK_CYC
) (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    ddrb2_if.dev BUS,
    input wire logic ERR_INJ_IN,
    input wire logic [`DDRB2_ADDR_W-1:0] ERR_ADDR_IN,
    input wire logic [1:0] ERR_LANE_IN,
    input wire logic [4:0] ERR_BIT_IN,
    output logic ECC_OFF_OUT,
    output logic CORR_OUT,
    output logic DLL_LOCK_OUT
);
    localparam int LW = `DDRB2_LANE_W;

    ddrb2_pkg::ddrb2_cmd_e pipe_ff [`DDRB2_PIPE];
    logic [`DDRB2_ADDR_W-1:0] apipe_ff [`DDRB2_PIPE];
    logic [`DDRB2_CW_W-1:0] mem_ff [`DDRB2_DEPTH][`DDRB2_LANES];
    logic [`DDRB2_DQ_W-1:0] wb1_ff;
    logic [`DDRB2_LANES-1:0] m1_ff;
    logic [`DDRB2_DQ_W-1:0] dq_out_ff;
    logic dq_oe_n_ff;
    logic [`DDRB2_DQ_W-1:0] hold_ff;
    logic ecc_off_ff;
    logic corr_ff;
    logic kprev_ff;
    logic [1:0] stall_ff;
    logic [`DDRB2_LOCK_W-1:0] dll_cnt_ff;
    logic lock_ff;

    ddrb2_pkg::ddrb2_cmd_e cmd_now;
    wire wr_now;
    wire rd1;
    wire rd2;
    wire clk_stopped;
    wire dll_hold;
    wire [`DDRB2_ADDR_W-1:0] waddr;
    wire [`DDRB2_ADDR_W-1:0] raddr;
    logic [`DDRB2_CW_W-1:0] wcw_new [`DDRB2_LANES];
    logic [`DDRB2_WORD_W-1:0] rdat [`DDRB2_LANES];
    logic [`DDRB2_LANES-1:0] wr_en;
    logic [`DDRB2_LANES-1:0] half;
    logic [`DDRB2_LANES-1:0] rcorr;
    logic [`DDRB2_DQ_W-1:0] rd_lo;
    logic [`DDRB2_DQ_W-1:0] rd_hi;

    // Only the primary edge takes a command; strobe high is a deselect
    assign cmd_now = (!BUS.k_phase || BUS.load_strobe_n) ?
                     ddrb2_pkg::CMD_NOP :
                     (BUS.rd_wr_n ? ddrb2_pkg::CMD_RD : ddrb2_pkg::CMD_WR);
    assign wr_now = pipe_ff[`DDRB2_ST_WB2] == ddrb2_pkg::CMD_WR;
    assign rd1 = pipe_ff[`DDRB2_ST_RD1] == ddrb2_pkg::CMD_RD;
    assign rd2 = pipe_ff[`DDRB2_ST_RD2] == ddrb2_pkg::CMD_RD;
    assign waddr = apipe_ff[`DDRB2_ST_WB2];
    assign raddr = apipe_ff[`DDRB2_ST_RD1];

    // Every command walks the same fixed pipe, so a burst cannot be cut
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            for (int i = 0; i < `DDRB2_PIPE; i++)
            begin
                pipe_ff[i] <= ddrb2_pkg::CMD_NOP;
                apipe_ff[i] <= '0;
            end
        end
        else
        begin
            pipe_ff[0] <= cmd_now;
            apipe_ff[0] <= BUS.word_address_inputs;
            for (int i = 1; i < `DDRB2_PIPE; i++)
            begin
                pipe_ff[i] <= pipe_ff[i - 1];
                apipe_ff[i] <= apipe_ff[i - 1];
            end
        end
    end

    // First write beat and its masks on the next primary edge
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            wb1_ff <= '0;
            m1_ff <= '1;
        end
        else if (pipe_ff[`DDRB2_ST_WB1] == ddrb2_pkg::CMD_WR)
        begin
            wb1_ff <= BUS.dq;
            m1_ff <= BUS.lane_write_mask_n;
        end
    end

    for (genvar l = 0; l < `DDRB2_LANES; l++)
    begin : g_lane
        wire [`DDRB2_WORD_W-1:0] wold;
        wire [LW-1:0] lo;
        wire [LW-1:0] hi;
        wire [`DDRB2_CW_W-1:0] rcw;

        assign wold = ddrb2_pkg::ham_dec(mem_ff[waddr][l], !ecc_off_ff);
        // Lane l owns bits l*9 .. l*9+8 of each beat
        assign lo = m1_ff[l] ? wold[LW-1:0] : wb1_ff[l*LW +: LW];
        assign hi = BUS.lane_write_mask_n[l] ? wold[2*LW-1:LW] :
                    BUS.dq[l*LW +: LW];
        assign wcw_new[l] = ddrb2_pkg::ham_enc({hi, lo});
        assign wr_en[l] = wr_now &&
                          !(m1_ff[l] && BUS.lane_write_mask_n[l]);
        assign half[l] = wr_now &&
                         (m1_ff[l] != BUS.lane_write_mask_n[l]);

        assign rcw = mem_ff[raddr][l];
        assign rdat[l] = ddrb2_pkg::ham_dec(rcw, !ecc_off_ff);
        assign rcorr[l] = !ecc_off_ff &&
                          ddrb2_pkg::ham_syn(rcw) != '0 &&
                          ddrb2_pkg::ham_syn(rcw) <=
                          `DDRB2_CHK_W'(`DDRB2_CW_W);
        // Even word goes out first, odd word second
        assign rd_lo[l*LW +: LW] = rdat[l][LW-1:0];
        assign rd_hi[l*LW +: LW] = rdat[l][2*LW-1:LW];
    end

    // Array update on the second beat; a fault injection follows it
    always_ff @(posedge CLK_IN)
    begin
        for (int l = 0; l < `DDRB2_LANES; l++)
        begin
            if (wr_en[l])
            begin
                mem_ff[waddr][l] <= wcw_new[l];
            end
            if (ERR_INJ_IN && ERR_LANE_IN == l[1:0] &&
                ERR_BIT_IN < 5'(`DDRB2_CW_W))
            begin
                mem_ff[ERR_ADDR_IN][l][ERR_BIT_IN] <=
                    ~mem_ff[ERR_ADDR_IN][l][ERR_BIT_IN];
            end
        end
    end

    // Read beats leave 2.5 primary cycles after the command
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            dq_out_ff <= '0;
            dq_oe_n_ff <= 1'b1;
            hold_ff <= '0;
            corr_ff <= 1'b0;
        end
        else
        begin
            dq_out_ff <= rd1 ? rd_lo : (rd2 ? hold_ff : '0);
            dq_oe_n_ff <= !(rd1 || rd2);
            hold_ff <= rd1 ? rd_hi : hold_ff;
            corr_ff <= rd1 && (|rcorr);
        end
    end

    // Correction stays off from the first half write until power-down
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            ecc_off_ff <= 1'b0;
        end
        else
        begin
            ecc_off_ff <= ecc_off_ff || (|half);
        end
    end

    assign clk_stopped = stall_ff >= 2'(`DDRB2_STOP_CYC);
    assign dll_hold = !BUS.doff_n || clk_stopped;

    // A phase that stops toggling counts as a stopped clock
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            kprev_ff <= 1'b0;
            stall_ff <= '0;
        end
        else
        begin
            kprev_ff <= BUS.k_phase;
            if (BUS.k_phase != kprev_ff)
            begin
                stall_ff <= '0;
            end
            else if (!clk_stopped)
            begin
                stall_ff <= stall_ff + 2'h1;
            end
        end
    end

    // Lock needs an unbroken run of primary edges with the loop enabled
    always_ff @(posedge CLK_IN or negedge RESETN_IN)
    begin
        if (!RESETN_IN)
        begin
            dll_cnt_ff <= '0;
            lock_ff <= 1'b0;
        end
        else
        begin
            if (dll_hold)
            begin
                dll_cnt_ff <= '0;
            end
            else if (BUS.k_phase &&
                     dll_cnt_ff != `DDRB2_LOCK_W'(LOCK_CYCLES))
            begin
                dll_cnt_ff <= dll_cnt_ff + `DDRB2_LOCK_W'(1);
            end
            lock_ff <= !dll_hold &&
                       dll_cnt_ff == `DDRB2_LOCK_W'(LOCK_CYCLES);
        end
    end

    assign BUS.dq_dev_out = dq_out_ff;
    assign BUS.dq_dev_oe_n = dq_oe_n_ff;
    assign ECC_OFF_OUT = ecc_off_ff;
    assign CORR_OUT = corr_ff;
    assign DLL_LOCK_OUT = lock_ff;
endmodule
`default_nettype wire

// [ddrb2_monitor.sv]
// Pin protocol checks between the SRAM core and its controller
`timescale 1ns/1ps
`default_nettype none
`include "ddrb2_defines.svh"
module ddrb2_monitor (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic k_phase_in,
    input wire logic load_strobe_n_in,
    input wire logic rd_wr_n_in,
    input wire logic [`DDRB2_LANES-1:0] lane_write_mask_n_in,
    input wire logic dq_ctl_oe_n_in,
    input wire logic dq_dev_oe_n_in
);
    wire rd_cmd = k_phase_in & ~load_strobe_n_in & rd_wr_n_in;
    wire wr_cmd = k_phase_in & ~load_strobe_n_in & ~rd_wr_n_in;
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    rd_beats_a: assert property (
        rd_cmd |-> ##5 !dq_dev_oe_n_in ##1 !dq_dev_oe_n_in)
        else $error("read beats");
    rd_release_a: assert property (
        rd_cmd ##2 !rd_cmd |-> ##5 dq_dev_oe_n_in)
        else $error("read release");
    wr_beats_a: assert property (
        wr_cmd |-> ##2 (!dq_ctl_oe_n_in && dq_dev_oe_n_in)[*2])
        else $error("wr beats");
    wr_release_a: assert property (
        wr_cmd ##2 !wr_cmd |-> ##2 dq_ctl_oe_n_in)
        else $error("write release");
    cmd_phase_a: assert property (
        !load_strobe_n_in |-> k_phase_in) else $error("command phase");
    dev_cause_a: assert property (
        $fell(dq_dev_oe_n_in) |-> $past(rd_cmd, 5))
        else $error("stray drive");
    mask_idle_a: assert property (
        dq_ctl_oe_n_in |-> &lane_write_mask_n_in) else $error("stray mask");
    no_clash_a: assert property (
        dq_dev_oe_n_in || dq_ctl_oe_n_in) else $error("bus clash");
endmodule
`default_nettype wire

// [ddrb2_tb.sv]
// Bench joining the SRAM core and its controller end to end
`timescale 1ns/1ps
`default_nettype none
`include "ddrb2_defines.svh"
module ddrb2_tb;
    localparam logic [71:0] DA = {8{9'h0A5}};
    localparam logic [71:0] DB = {8{9'h15A}};
    localparam logic [71:0] DC = {8{9'h0F0}};
    localparam logic [71:0] E1 = {DB[71:54], DA[53:45], DB[44:18], DA[17:9],
        DB[8:0]};
    localparam logic [71:0] E2 = {DC[71:63], DB[62:54], DC[53:0]};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic vld = 1'b0;
    logic rd = 1'b0;
    logic relock = 1'b0;
    logic inj = 1'b0;
    logic [4:0] err_bit = 5'h02;
    int n_corr = 0;
    logic [3:0] addr = 4'h0;
    logic [71:0] wdata = '0;
    logic [7:0] mask = 8'hFF;
    logic req_rdy, ready, rdv, ecc_off, corr, lock;
    logic [71:0] rdata;
    int n_fail = 0;
    int check_count = 0;
    int cyc = 0;
    ddrb2_if ddrb2_if_i ();
    ddrb2_dev #(.LOCK_CYCLES(16)) ddrb2_dev_i (.CLK_IN(clk), .RESETN_IN(rst_n),
        .BUS(ddrb2_if_i), .ERR_INJ_IN(inj), .ERR_ADDR_IN(4'h5),
        .ERR_LANE_IN(2'h0), .ERR_BIT_IN(err_bit), .ECC_OFF_OUT(ecc_off),
        .CORR_OUT(corr), .DLL_LOCK_OUT(lock));
    ddrb2_ctl #(.IMP_CYCLES(20), .LOCK_CYCLES(16)) ddrb2_ctl_i (.CLK_IN(clk),
        .RESETN_IN(rst_n), .BUS(ddrb2_if_i), .REQ_VALID_IN(vld),
        .REQ_READY_OUT(req_rdy), .REQ_RD_IN(rd), .REQ_ADDR_IN(addr),
        .REQ_WDATA_IN(wdata), .REQ_MASK_N_IN(mask), .RELOCK_IN(relock),
        .READY_OUT(ready), .RD_VALID_OUT(rdv), .RD_DATA_OUT(rdata));
    ddrb2_monitor ddrb2_monitor_i (.clk_in(clk), .resetn_in(rst_n),
        .k_phase_in(ddrb2_if_i.k_phase), .rd_wr_n_in(ddrb2_if_i.rd_wr_n),
        .load_strobe_n_in(ddrb2_if_i.load_strobe_n),
        .lane_write_mask_n_in(ddrb2_if_i.lane_write_mask_n),
        .dq_ctl_oe_n_in(ddrb2_if_i.dq_ctl_oe_n),
        .dq_dev_oe_n_in(ddrb2_if_i.dq_dev_oe_n));
    always #25 clk = ~clk;
    task automatic finish_test();
        if (n_fail == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (corr === 1'b1)
            n_corr <= n_corr + 1;
        if (cyc == 4000)
        begin
            n_fail = n_fail + 1;
            finish_test();
        end
    end
    task automatic chk(input string what, input logic [71:0] exp, got);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic push(input logic r, input logic [3:0] a,
        input logic [71:0] d, input logic [7:0] m);
        @(negedge clk);
        vld = 1'b1;
        rd = r;
        addr = a;
        wdata = d;
        mask = m;
        for (int n = 0; n < 200 && req_rdy !== 1'b1; n++)
            @(negedge clk);
        @(negedge clk);
        vld = 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [71:0] exp);
        push(1'b1, a, '0, 8'hFF);
        for (int n = 0; n < 300 && rdv !== 1'b1; n++)
            @(negedge clk);
        chk("read valid", 72'h1, {71'h0, rdv});
        chk("read data", exp, rdata);
    endtask
    task automatic pulse_inj(input logic [4:0] b);
        @(negedge clk);
        err_bit = b;
        inj = 1'b1;
        @(negedge clk);
        inj = 1'b0;
    endtask
    task automatic wait_ready();
        for (int n = 0; n < 500 && ready !== 1'b1; n++)
            @(negedge clk);
        chk("ready", 72'h1, {71'h0, ready});
    endtask
    // Requests pile up while the controller relocks, then drain in order
    task automatic t_fifo();
        @(negedge clk);
        relock = 1'b1;
        @(negedge clk);
        relock = 1'b0;
        for (int i = 0; i < 8; i++)
            push(1'b0, 4'(8 + i), {8{9'(i)}}, 8'h00);
        chk("fifo full", 72'h0, {71'h0, req_rdy});
        chk("relock", 72'h0, {71'h0, ready});
        chk("dll reset", 72'h0, {71'h0, lock});
        wait_ready();
        chk("dll relock", 72'h1, {71'h0, lock});
        rd_chk(4'h8, '0);
        rd_chk(4'hF, {8{9'h007}});
    endtask
    task automatic t_mask();
        int c0;
        push(1'b0, 4'h5, DA, 8'h00);
        push(1'b0, 4'h5, DB, 8'h22);
        rd_chk(4'h5, E1);
        pulse_inj(5'h02);
        c0 = n_corr;
        rd_chk(4'h5, E1);
        chk("corrected", 72'h1, 72'(n_corr - c0));
        chk("ecc on", 72'h0, {71'h0, ecc_off});
        push(1'b0, 4'h5, DC, 8'h40);
        rd_chk(4'h5, E2);
        chk("ecc off", 72'h1, {71'h0, ecc_off});
        pulse_inj(5'h04);
        c0 = n_corr;
        rd_chk(4'h5, E2 ^ 72'h2);
        chk("no correction", 72'h0, 72'(n_corr - c0));
    endtask
    initial
    begin
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        wait_ready();
        chk("dll lock", 72'h1, {71'h0, lock});
        push(1'b0, 4'h3, DA, 8'h00);
        rd_chk(4'h3, DA);
        t_fifo();
        t_mask();
        finish_test();
    end
endmodule
`default_nettype wire
